// ### src/dcpb_pkg.sv
package dcpb_pkg;

  // ------------------------------------------------------------------
  // Host variants
  // ------------------------------------------------------------------
  localparam logic DCPB_HOST_W32 = 1'b0;
  localparam logic DCPB_HOST_W16 = 1'b1;

  // ------------------------------------------------------------------
  // Host access sizes (log2 of the byte count)
  // ------------------------------------------------------------------
  localparam logic [1:0] DCPB_SIZE_8 = 2'h0;
  localparam logic [1:0] DCPB_SIZE_16 = 2'h1;
  localparam logic [1:0] DCPB_SIZE_32 = 2'h2;

  // ------------------------------------------------------------------
  // Address field positions
  // ------------------------------------------------------------------
  localparam int DCPB_ADDR_W = 6;
  localparam int DCPB_DATA_W = 8;
  localparam int DCPB_W32_ADDR_LSB = 2;
  localparam int DCPB_W16_ADDR_LSB = 1;

  // ------------------------------------------------------------------
  // Reset control bit positions and reset values
  // ------------------------------------------------------------------
  localparam int DCPB_SITE_RST_BIT = 0;
  localparam int DCPB_EXT_RST_BIT = 1;
  localparam logic [1:0] DCPB_RST_CTRL_RESET = 2'h3;

  // ------------------------------------------------------------------
  // Synchroniser depth
  // ------------------------------------------------------------------
  localparam int DCPB_SYNC_STAGES = 3;

  // ------------------------------------------------------------------
  // Transfer states
  // ------------------------------------------------------------------
  typedef enum logic [4:0] {
    DCPB_IDLE = 5'h01,
    DCPB_STROBE = 5'h02,
    DCPB_CAPTURE = 5'h04,
    DCPB_RELEASE = 5'h08,
    DCPB_DONE = 5'h10
  } dcpb_state_t;

endpackage

// ### src/dcpb_ack_sync.sv
`timescale 1ns/1ns
module dcpb_ack_sync
  import dcpb_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Asynchronous pin
  input wire logic async_in,
  // Filtered level
  output logic level_out
);

  // ------------------------------------------------------------------
  // Three-stage chain and agreement filter
  // ------------------------------------------------------------------
  logic [DCPB_SYNC_STAGES-1:0] chain_q;
  logic [DCPB_SYNC_STAGES-1:0] chain_d;
  logic level_q;
  logic level_d;

  // Shift the pin in; idle level of the pulled-up line is high
  always_comb
  begin
    chain_d = {chain_q[DCPB_SYNC_STAGES-2:0], async_in};
    level_d = level_q;
    if (chain_q[1] == chain_q[2])
    begin
      level_d = chain_q[2]; // Change counts once stages agree
    end
  end

  // Register chain and filtered level
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      chain_q <= '1;
      level_q <= 1'b1;
    end
    else
    begin
      chain_q <= chain_d;
      level_q <= level_d;
    end
  end

  assign level_out = level_q;

endmodule

// ### src/dcpb_reset_ctrl.sv
`timescale 1ns/1ns
module dcpb_reset_ctrl
  import dcpb_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Control register write port
  input wire logic wr_en_in,
  input wire logic [1:0] wr_data_in,
  // Register contents and reset pins
  output logic [1:0] ctrl_out,
  output logic site_reset_n_out,
  output logic extender_reset_n_out
);

  // ------------------------------------------------------------------
  // Peripheral reset register
  // ------------------------------------------------------------------
  logic [1:0] peripheral_reset_reg_q;
  logic [1:0] peripheral_reset_reg_d;
  logic site_n_q;
  logic site_n_d;
  logic ext_n_q;
  logic ext_n_d;

  // Next register value and pin levels (bit set holds reset active)
  always_comb
  begin
    peripheral_reset_reg_d = peripheral_reset_reg_q;
    if (wr_en_in)
    begin
      peripheral_reset_reg_d = wr_data_in;
    end
    site_n_d = ~peripheral_reset_reg_q[DCPB_SITE_RST_BIT];
    ext_n_d = ~peripheral_reset_reg_q[DCPB_EXT_RST_BIT];
  end

  // Register state; pins held in reset during board reset
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      peripheral_reset_reg_q <= DCPB_RST_CTRL_RESET;
      site_n_q <= 1'b0;
      ext_n_q <= 1'b0;
    end
    else
    begin
      peripheral_reset_reg_q <= peripheral_reset_reg_d;
      site_n_q <= site_n_d;
      ext_n_q <= ext_n_d;
    end
  end

  assign ctrl_out = peripheral_reset_reg_q;
  assign site_reset_n_out = site_n_q;
  assign extender_reset_n_out = ext_n_q;

endmodule

// ### src/dcpb_port.sv
// Functional notes
// - A control bit in the peripheral reset register drives the shared reset of all module sites.
// - A second bit of that register drives the separate extender reset.
// - On the 32-bit host each module byte sits on D0..D7 of one word of a 64Kx32 sub-area.
// - On the 32-bit host 8, 16 and 32-bit accesses are taken, each one byte transfer.
// - On the 32-bit host D8..D31 are dropped on writes and of any value on reads.
// - On the 16-bit host each module byte is the low byte of one word of a 64Kx16 sub-area.
// - On the 16-bit host only 8 and 16-bit accesses are taken.
// - On the 16-bit host D8..D15 are ignored on writes and undefined on reads.
// - Transfers use one data strobe plus a separate write-enable level.
// - The host stays stalled until ready arrives; there is no timeout.
// - The strobe is low only while the host accesses the module sub-area.
// - Write enable is low for writes and high for reads.
// - The module address comes from host word-address lines A2..A7 on the 32-bit host.
`timescale 1ns/1ns
module dcpb_port
  import dcpb_pkg::*;
#(
  parameter logic HOST_VARIANT = DCPB_HOST_W32,
  parameter int HOST_ADDR_W = 18
)
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Host access request
  input wire logic host_req_in,
  input wire logic host_sel_in,
  input wire logic host_write_in,
  input wire logic [1:0] host_size_in,
  input wire logic [HOST_ADDR_W-1:0] host_addr_in,
  input wire logic [31:0] host_wdata_in,
  // Host access answer
  output logic host_busy_out,
  output logic host_done_out,
  output logic host_error_out,
  output logic [31:0] host_rdata_out,
  // Reset control register port
  input wire logic rst_ctrl_wr_in,
  input wire logic [1:0] rst_ctrl_data_in,
  output logic [1:0] rst_ctrl_out,
  // Module bus pins
  output logic [DCPB_ADDR_W-1:0] module_addr_out,
  input wire logic [DCPB_DATA_W-1:0] module_data_in,
  output logic [DCPB_DATA_W-1:0] module_data_out,
  output logic module_data_oe_n_out,
  output logic module_strobe_n_out,
  output logic module_write_n_out,
  input wire logic module_ack_n_in,
  // Module reset pins
  output logic site_reset_n_out,
  output logic extender_reset_n_out
);

  // ------------------------------------------------------------------
  // Derived constants
  // ------------------------------------------------------------------
  // Offset of the module address inside the host byte address
  localparam int ADDR_LSB = (HOST_VARIANT == DCPB_HOST_W32) ?
    DCPB_W32_ADDR_LSB : DCPB_W16_ADDR_LSB;

  // ------------------------------------------------------------------
  // Sub-blocks
  // ------------------------------------------------------------------
  logic ack_n_sync;

  dcpb_ack_sync u_ack_sync (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(module_ack_n_in),
    .level_out(ack_n_sync)
  );

  // Reset register and module reset pins
  dcpb_reset_ctrl u_reset_ctrl (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_en_in(rst_ctrl_wr_in),
    .wr_data_in(rst_ctrl_data_in),
    .ctrl_out(rst_ctrl_out),
    .site_reset_n_out(site_reset_n_out),
    .extender_reset_n_out(extender_reset_n_out)
  );

  // ------------------------------------------------------------------
  // Read data pins
  // ------------------------------------------------------------------
  logic [DCPB_DATA_W-1:0] data_in_sync;

  // Each data pin crosses through its own three-stage agreement filter;
  // the card holds the byte steady while ready is being filtered
  for (genvar gi = 0; gi < DCPB_DATA_W; gi++)
  begin
    dcpb_ack_sync u_data_sync (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .async_in(module_data_in[gi]),
      .level_out(data_in_sync[gi])
    );
  end

  // ------------------------------------------------------------------
  // Transfer state
  // ------------------------------------------------------------------
  // Request fields latched at accept, pin levels and answer flags
  dcpb_state_t state_q;
  dcpb_state_t state_d;
  logic [DCPB_ADDR_W-1:0] addr_q;
  logic [DCPB_ADDR_W-1:0] addr_d;
  logic [DCPB_DATA_W-1:0] wdata_q;
  logic [DCPB_DATA_W-1:0] wdata_d;
  logic [DCPB_DATA_W-1:0] rdata_q;
  logic [DCPB_DATA_W-1:0] rdata_d;
  logic write_q;
  logic write_d;
  logic strobe_n_q;
  logic strobe_n_d;
  logic write_n_q;
  logic write_n_d;
  logic oe_n_q;
  logic oe_n_d;
  logic done_q;
  logic done_d;
  logic error_q;
  logic error_d;
  logic size_ok;

  // ------------------------------------------------------------------
  // Access size check
  // ------------------------------------------------------------------
  // Access sizes allowed by the host variant
  always_comb
  begin
    if (HOST_VARIANT == DCPB_HOST_W32)
    begin
      size_ok = (host_size_in == DCPB_SIZE_8) ||
        (host_size_in == DCPB_SIZE_16) || (host_size_in == DCPB_SIZE_32);
    end
    else
    begin
      size_ok = (host_size_in == DCPB_SIZE_8) ||
        (host_size_in == DCPB_SIZE_16);
    end
  end

  // ------------------------------------------------------------------
  // Transfer sequencer
  // ------------------------------------------------------------------
  // Next-state logic for one byte transfer
  always_comb
  begin
    // Everything holds; answer flags pulse for one cycle only
    state_d = state_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    write_d = write_q;
    strobe_n_d = strobe_n_q;
    write_n_d = write_n_q;
    oe_n_d = oe_n_q;
    done_d = 1'b0;
    error_d = 1'b0;
    case (state_q)
      DCPB_IDLE:
      begin
        if (host_req_in && host_sel_in)
        begin
          if (size_ok)
          begin
            // word address lines to module address
            // low byte of the host data word
            addr_d = host_addr_in[ADDR_LSB +: DCPB_ADDR_W];
            wdata_d = host_wdata_in[DCPB_DATA_W-1:0];
            write_d = host_write_in;
            strobe_n_d = 1'b0;
            write_n_d = ~host_write_in;
            oe_n_d = ~host_write_in;
            state_d = DCPB_STROBE;
          end
          else
          begin
            // Refused width answers at once so the host is not stalled
            error_d = 1'b1; // Unsupported width, no bus cycle
            done_d = 1'b1;
          end
        end
      end
      DCPB_STROBE:
      begin
        // An absent card never answers: the host stalls here for good
        // wait for ready, no timeout
        if (!ack_n_sync)
        begin
          state_d = DCPB_CAPTURE;
        end
      end
      DCPB_CAPTURE:
      begin
        if (!write_q)
        begin
          // Filtered byte has stood since ready was filtered
          rdata_d = data_in_sync;
        end
        strobe_n_d = 1'b1;
        write_n_d = 1'b1;
        state_d = DCPB_RELEASE;
      end
      DCPB_RELEASE:
      begin
        // Waiting for ready to rise keeps it from ending the next cycle
        // wait for ready to go high again
        oe_n_d = 1'b1;
        if (ack_n_sync)
        begin
          done_d = 1'b1;
          state_d = DCPB_DONE;
        end
      end
      DCPB_DONE:
      begin
        state_d = DCPB_IDLE;
      end
      default:
      begin
        // Stray state code: release the pins and restart
        state_d = DCPB_IDLE;
        strobe_n_d = 1'b1;
        write_n_d = 1'b1;
        oe_n_d = 1'b1;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------------
  // Register transfer state
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      state_q <= DCPB_IDLE;
      addr_q <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      write_q <= 1'b0;
      strobe_n_q <= 1'b1;
      write_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      done_q <= 1'b0;
      error_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      write_q <= write_d;
      strobe_n_q <= strobe_n_d;
      write_n_q <= write_n_d;
      oe_n_q <= oe_n_d;
      done_q <= done_d;
      error_q <= error_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // host held while transfer runs
  assign host_busy_out = (state_q != DCPB_IDLE) && (state_q != DCPB_DONE);
  // Answer flags pulse for one cycle
  assign host_done_out = done_q;
  assign host_error_out = error_q;
  // upper read bits read as zero
  assign host_rdata_out = {{(32-DCPB_DATA_W){1'b0}}, rdata_q};

  // ------------------------------------------------------------------
  // Module pins
  // ------------------------------------------------------------------
  // Pins come straight from their flip-flops
  assign module_addr_out = addr_q;
  assign module_data_out = wdata_q;
  assign module_data_oe_n_out = oe_n_q;
  assign module_strobe_n_out = strobe_n_q;
  assign module_write_n_out = write_n_q;

endmodule

// ### tb/dcpb_port_sva.sv
`timescale 1ns/1ns
module dcpb_port_sva
  import dcpb_pkg::*;
#(
  parameter logic HOST_VARIANT = DCPB_HOST_W32,
  parameter int HOST_ADDR_W = 18
)
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Host side
  input wire logic host_req_in,
  input wire logic host_sel_in,
  input wire logic host_write_in,
  input wire logic [1:0] host_size_in,
  input wire logic [HOST_ADDR_W-1:0] host_addr_in,
  input wire logic host_busy_out,
  input wire logic host_done_out,
  input wire logic host_error_out,
  // Reset control
  input wire logic [1:0] rst_ctrl_out,
  input wire logic site_reset_n_out,
  input wire logic extender_reset_n_out,
  // Module pins
  input wire logic [DCPB_ADDR_W-1:0] module_addr_out,
  input wire logic module_data_oe_n_out,
  input wire logic module_strobe_n_out,
  input wire logic module_write_n_out,
  input wire logic module_ack_n_in
);
  // ------------------------------------------------------------------
  // Port checks
  // ------------------------------------------------------------------
  localparam int ADDR_LSB = (HOST_VARIANT == DCPB_HOST_W32) ?
    DCPB_W32_ADDR_LSB : DCPB_W16_ADDR_LSB;
  logic [5:0] addr_field;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // Word address field of the host address
  assign addr_field = host_addr_in[ADDR_LSB +: DCPB_ADDR_W];
  AST_STB_CAUSE: assert property ($fell(module_strobe_n_out) |->
    $past(host_req_in) && $past(host_sel_in)) else $error("strobe cause");
  AST_NO_SEL: assert property (!host_busy_out && !host_sel_in &&
    module_strobe_n_out |=> module_strobe_n_out) else $error("stray strobe");
  AST_WRITE_LVL: assert property ($fell(module_strobe_n_out) |->
    module_write_n_out == !$past(host_write_in)) else $error("write level");
  AST_ADDR_MAP: assert property ($fell(module_strobe_n_out) |->
    module_addr_out == $past(addr_field)) else $error("address map");
  AST_OE_DIR: assert property (!module_strobe_n_out |->
    module_data_oe_n_out == module_write_n_out) else $error("data dir");
  AST_ACK_FILT: assert property ($fell(module_ack_n_in) &&
    !module_strobe_n_out |-> !module_strobe_n_out [*4] ##[1:3]
    module_strobe_n_out) else $error("ready filter");
  AST_STALL: assert property (!module_strobe_n_out |->
    host_busy_out && !host_done_out) else $error("stall lost");
  AST_REFUSE: assert property (host_req_in && host_sel_in &&
    (host_size_in == 2'h3 || (HOST_VARIANT == DCPB_HOST_W16 &&
    host_size_in == DCPB_SIZE_32)) && !host_busy_out && !host_done_out &&
    module_strobe_n_out |=> host_done_out && host_error_out &&
    module_strobe_n_out) else $error("size refusal");
  AST_SITE_PIN: assert property (site_reset_n_out ==
    !$past(rst_ctrl_out[DCPB_SITE_RST_BIT])) else $error("site reset");
  AST_EXT_PIN: assert property (extender_reset_n_out ==
    !$past(rst_ctrl_out[DCPB_EXT_RST_BIT])) else $error("ext reset");
endmodule

bind dcpb_port dcpb_port_sva #(.HOST_VARIANT(HOST_VARIANT),
  .HOST_ADDR_W(HOST_ADDR_W)) dcpb_port_sva_inst (
  .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
  .host_req_in(host_req_in), .host_sel_in(host_sel_in),
  .host_write_in(host_write_in), .host_size_in(host_size_in),
  .host_addr_in(host_addr_in), .host_busy_out(host_busy_out),
  .host_done_out(host_done_out), .host_error_out(host_error_out),
  .rst_ctrl_out(rst_ctrl_out), .site_reset_n_out(site_reset_n_out),
  .extender_reset_n_out(extender_reset_n_out),
  .module_addr_out(module_addr_out),
  .module_data_oe_n_out(module_data_oe_n_out),
  .module_strobe_n_out(module_strobe_n_out),
  .module_write_n_out(module_write_n_out),
  .module_ack_n_in(module_ack_n_in));

// ### tb/dcpb_card_model.sv
`timescale 1ns/1ns
module dcpb_card_model
(
  // Clock and tuning
  input wire logic core_clk_in,
  input wire logic [7:0] delay_in,
  input wire logic [7:0] rd_byte_in,
  // Module bus pins
  input wire logic strobe_n_in,
  input wire logic write_n_in,
  input wire logic [5:0] addr_in,
  input wire logic [7:0] data_in,
  output logic ack_n_out,
  output logic [7:0] data_out,
  // Captured write
  output logic [7:0] wr_byte_out,
  output logic [5:0] wr_addr_out
);
  // ------------------------------------------------------------------
  // Card response
  // ------------------------------------------------------------------
  initial
  begin
    ack_n_out = 1'b1;
    data_out = 8'h00;
    wr_byte_out = 8'h00;
    wr_addr_out = 6'h00;
  end
  always @(negedge strobe_n_in)
  begin
    repeat (delay_in) @(posedge core_clk_in);
    #3;
    if (write_n_in)
      data_out = rd_byte_in;
    else
    begin
      wr_byte_out = data_in;
      wr_addr_out = addr_in;
    end
    ack_n_out = 1'b0;
    @(posedge strobe_n_in);
    #2;
    // Ready floats back up, released data is scrambled
    ack_n_out = 1'b1;
    data_out = ~data_out;
  end
endmodule

// ### tb/tb_dcpb_port.sv
`timescale 1ns/1ns
module tb_dcpb_port
  import dcpb_pkg::*;
;
  // ------------------------------------------------------------------
  // Bench
  // ------------------------------------------------------------------
  logic clk = 1'b0, rst = 1'b1, req = 1'b0, sel = 1'b0, wr = 1'b0;
  logic rc_wr = 1'b0, busy, done, err, oe_n, stb_n, we_n, ack_n;
  logic site_n, ext_n, last_err;
  logic [1:0] size = 2'h0, rc_data = 2'h0, rc_q;
  logic [17:0] addr = 18'h0;
  logic [31:0] wdata = 32'h0, rdata, last_rd;
  logic [5:0] maddr, card_addr;
  logic [7:0] din, dout, card_byte, rd_byte = 8'h00, delay = 8'h02;
  int failures = 0, checks = 0, cyc = 0, n;
  logic done16, err16, stb16_n, we16_n, ack16_n, last_err16;
  logic [31:0] rdata16, last_rd16;
  logic [5:0] maddr16, card16_addr;
  logic [7:0] din16, dout16, card16_byte;
  always #4 clk = ~clk;
  dcpb_port dcpb_port_inst (.core_clk_in(clk), .sys_rst_in(rst),
    .host_req_in(req), .host_sel_in(sel), .host_write_in(wr),
    .host_size_in(size), .host_addr_in(addr), .host_wdata_in(wdata),
    .host_busy_out(busy), .host_done_out(done), .host_error_out(err),
    .host_rdata_out(rdata), .rst_ctrl_wr_in(rc_wr),
    .rst_ctrl_data_in(rc_data), .rst_ctrl_out(rc_q),
    .module_addr_out(maddr), .module_data_in(din),
    .module_data_out(dout), .module_data_oe_n_out(oe_n),
    .module_strobe_n_out(stb_n), .module_write_n_out(we_n),
    .module_ack_n_in(ack_n), .site_reset_n_out(site_n),
    .extender_reset_n_out(ext_n));
  dcpb_card_model dcpb_card_model_inst (.core_clk_in(clk),
    .delay_in(delay), .rd_byte_in(rd_byte), .strobe_n_in(stb_n),
    .write_n_in(we_n), .addr_in(maddr), .data_in(dout),
    .ack_n_out(ack_n), .data_out(din), .wr_byte_out(card_byte),
    .wr_addr_out(card_addr));
  // 16-bit host variant on the same host stimulus, with its own card
  dcpb_port #(.HOST_VARIANT(DCPB_HOST_W16)) w16_dcpb_port_inst (
    .core_clk_in(clk), .sys_rst_in(rst),
    .host_req_in(req), .host_sel_in(sel), .host_write_in(wr),
    .host_size_in(size), .host_addr_in(addr), .host_wdata_in(wdata),
    .host_busy_out(), .host_done_out(done16),
    .host_error_out(err16), .host_rdata_out(rdata16),
    .rst_ctrl_wr_in(rc_wr), .rst_ctrl_data_in(rc_data),
    .rst_ctrl_out(), .module_addr_out(maddr16),
    .module_data_in(din16), .module_data_out(dout16),
    .module_data_oe_n_out(), .module_strobe_n_out(stb16_n),
    .module_write_n_out(we16_n), .module_ack_n_in(ack16_n),
    .site_reset_n_out(), .extender_reset_n_out());
  dcpb_card_model w16_dcpb_card_model_inst (.core_clk_in(clk),
    .delay_in(delay), .rd_byte_in(rd_byte), .strobe_n_in(stb16_n),
    .write_n_in(we16_n), .addr_in(maddr16), .data_in(dout16),
    .ack_n_out(ack16_n), .data_out(din16), .wr_byte_out(card16_byte),
    .wr_addr_out(card16_addr));

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One host access, n counts cycles until done (100 means none)
  task automatic access(input logic w, s, input logic [1:0] sz,
    input logic [17:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= 1'b1;
    sel <= s;
    wr <= w;
    size <= sz;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    #1;
    n = 0;
    last_err16 = 1'bx;
    while (done !== 1'b1 && n < 100)
    begin
      if (done16 === 1'b1)
        last_err16 = err16;
      @(posedge clk);
      #1;
      n++;
    end
    if (done16 === 1'b1)
    begin
      last_err16 = err16;
      last_rd16 = rdata16;
    end
    last_err = err;
    last_rd = rdata;
    @(posedge clk);
  endtask

  task automatic t_rst_ctrl();
    logic [1:0] v;
    for (int i = 3; i >= 0; i--)
    begin
      v = 2'(i);
      @(posedge clk);
      rc_wr <= 1'b1;
      rc_data <= v;
      @(posedge clk);
      rc_wr <= 1'b0;
      @(posedge clk);
      #1;
      check("reset reg", rc_q, v);
      check("site pin", site_n, !v[0]);
      check("ext pin", ext_n, !v[1]);
    end
  endtask

  task automatic t_xfer();
    logic [17:0] a;
    for (int sz = 0; sz < 3; sz++)
    begin
      delay = 8'(sz);
      rd_byte = 8'h5a ^ 8'(sz);
      a = 18'h3ff03 + 18'(sz * 'h54);
      access(1'b1, 1'b1, 2'(sz), a, 32'hffff_ff00 | ~rd_byte);
      check("write err", last_err, 1'b0);
      check("write byte", card_byte, 8'(~rd_byte));
      check("write addr", card_addr, a[7:2]);
      check("w16 write size", last_err16, sz == 2);
      if (sz < 2)
      begin
        check("w16 write byte", card16_byte, 8'(~rd_byte));
        check("w16 write addr", card16_addr, a[6:1]);
      end
      access(1'b0, 1'b1, 2'(sz), a, 32'h0);
      check("read byte", last_rd[7:0], rd_byte);
      check("w16 read size", last_err16, sz == 2);
      if (sz < 2)
        check("w16 read byte", last_rd16[7:0], rd_byte);
    end
  endtask

  task automatic t_refuse();
    access(1'b0, 1'b1, 2'h3, 18'h0, 32'h0);
    check("refused err", last_err, 1'b1);
    check("w16 refused err", last_err16, 1'b1);
    access(1'b0, 1'b0, DCPB_SIZE_8, 18'h0, 32'h0);
    check("no sel done", n, 100);
  endtask

  task automatic t_stall();
    delay = 8'd40;
    access(1'b0, 1'b1, DCPB_SIZE_32, 18'h10, 32'h0);
    check("stall length", n >= 40, 1'b1);
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      give_verdict();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("reset reg init", rc_q, DCPB_RST_CTRL_RESET);
    check("site pin init", site_n, 1'b0);
    check("ext pin init", ext_n, 1'b0);
    t_rst_ctrl();
    t_xfer();
    t_refuse();
    t_stall();
    give_verdict();
  end
endmodule
